// ### design/handshake_io_port.sv
// Eight-line bit-programmable I/O port with two-wire handshake behind an APB slave
// Functional notes
// RULE_01 - Each of the eight lines has its own direction bit, any mix allowed.
// RULE_02 - One port-wide bit turns all output lines into open-drain drivers.
// RULE_03 - Port stays usable for plain I/O regardless of any bus configuration; in send mode the code drops data writes while a byte is in flight.
// RULE_04 - Handshake mode uses two borrowed lines as data-valid strobe and ready.
// RULE_05 - Top line direction decides which handshake line is strobe-out or ready-out.
// RULE_06 - Undriven input lines are held at their last valid level by a keeper; only the pins register reads keep_q, the receiver captures port_in.
// RULE_07 - Sender puts data, strobes valid, waits ready, releases strobe before next byte.
`default_nettype none
module handshake_io_port (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Eight port lines
	input  wire logic [7:0]  port_in,
	input  wire logic [7:0]  port_driven,
	output logic [7:0]       port_out,
	output logic [7:0]       port_oe_n,
	// Handshake line a: data_valid_strobe_n
	input  wire logic        handshake_pin_a_i,
	output logic             handshake_pin_a_o,
	output logic             handshake_pin_a_oe_n,
	// Handshake line b: ready_acknowledge
	input  wire logic        handshake_pin_b_i,
	output logic             handshake_pin_b_o,
	output logic             handshake_pin_b_oe_n
);
	// Word index from byte address, used by read and write decode
	function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
		is_reg = (addr[7:2] == off[7:2]);
	endfunction

	logic [7:0]         dir_q;
	logic [7:0]         data_q;
	hsio_pkg::ctrl_t    ctrl_q;
	logic [7:0]         keep_q;
	logic [7:0]         rxdata_q;
	logic               rx_full_q;
	logic               rdy_q;
	hsio_pkg::hs_state_t tx_q;
	hsio_pkg::hs_state_t tx_d;
	hsio_pkg::pad_t     pad_a_q;
	hsio_pkg::pad_t     pad_b_q;
	logic [7:0]         port_out_q;
	logic [7:0]         port_oe_n_q;
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;

	// Bus phase decode: the answer is prepared in setup and stands for one access cycle
	wire setup_ph  = psel & ~penable;
	wire access_ok = psel & penable & pready_q;
	wire wr_acc    = access_ok & pwrite;
	wire rd_acc    = access_ok & ~pwrite;
	wire hit_dir   = is_reg(paddr, hsio_pkg::OFF_DIR);
	wire hit_data  = is_reg(paddr, hsio_pkg::OFF_DATA);
	wire hit_ctrl  = is_reg(paddr, hsio_pkg::OFF_CTRL);
	wire hit_pins  = is_reg(paddr, hsio_pkg::OFF_PINS);
	wire hit_stat  = is_reg(paddr, hsio_pkg::OFF_STATUS);
	wire hit_rx    = is_reg(paddr, hsio_pkg::OFF_RXDATA);
	wire mapped    = (paddr[1:0] == 2'b00) &
	                 (hit_dir | hit_data | hit_ctrl | hit_pins | hit_stat | hit_rx);

	// Handshake role follows the top line direction: output means this end sends
	wire hs_on     = ctrl_q.hs_en;
	wire send_mode = hs_on & ~dir_q[hsio_pkg::TOP_LINE]; // RULE_05
	wire recv_mode = hs_on & dir_q[hsio_pkg::TOP_LINE];  // RULE_05
	wire tx_busy   = (tx_q != hsio_pkg::HS_IDLE);
	// A data write while a byte is in flight is dropped so the pins never change mid-transfer
	wire data_wr   = wr_acc & mapped & hit_data & ~tx_busy; // RULE_07
	wire dav_low   = ~handshake_pin_a_i;
	wire rx_take   = recv_mode & ~rdy_q & dav_low;          // RULE_04
	wire rx_clear  = rd_acc & mapped & hit_rx;

	// Read mux
	wire [31:0] rd_val =
		hit_dir  ? {24'h000000, dir_q} :
		hit_data ? {24'h000000, data_q} :
		hit_ctrl ? {30'h00000000, ctrl_q.hs_en, ctrl_q.od} :
		hit_pins ? {24'h000000, keep_q} :
		hit_stat ? {30'h00000000, rx_full_q, tx_busy} :
		{24'h000000, rxdata_q};

	// Pad drive: open-drain releases a line whose data is one
	wire [7:0] oe_n_d = dir_q | ({8{ctrl_q.od}} & data_q); // RULE_01 RULE_02

	// APB answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_ph;
			prdata_q  <= (setup_ph & ~pwrite & mapped) ? rd_val : 32'h00000000;
			pslverr_q <= setup_ph & ~mapped;
		end
	end

	// Software registers; direction is always writable, data only while no byte is in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q  <= hsio_pkg::DIR_RST;
			data_q <= hsio_pkg::DATA_RST;
			ctrl_q <= hsio_pkg::CTRL_RST;
		end else begin
			if (wr_acc & mapped & hit_dir) begin
				dir_q <= pwdata[7:0]; // RULE_01 RULE_03
			end
			if (data_wr) begin
				data_q <= pwdata[7:0]; // RULE_03
			end
			if (wr_acc & mapped & hit_ctrl) begin
				ctrl_q <= '{hs_en: pwdata[hsio_pkg::CTRL_HS_BIT],
				            od: pwdata[hsio_pkg::CTRL_OD_BIT]}; // RULE_02
			end
		end
	end

	// Keeper: a line follows the pad only while something drives it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keep_q <= hsio_pkg::KEEP_RST;
		end else begin
			keep_q <= (port_driven & port_in) | (~port_driven & keep_q); // RULE_06
		end
	end

	// Port pads straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_out_q  <= hsio_pkg::DATA_RST;
			port_oe_n_q <= 8'hFF;
		end else begin
			port_out_q  <= data_q;
			port_oe_n_q <= oe_n_d; // RULE_01 RULE_02
		end
	end

	// Sender next state: data settles one cycle before the strobe falls
	always_comb begin
		tx_d = tx_q;
		case (tx_q)
			hsio_pkg::HS_IDLE:      if (data_wr & send_mode) tx_d = hsio_pkg::HS_SETUP;
			hsio_pkg::HS_SETUP:     tx_d = hsio_pkg::HS_WAIT_RDY;
			hsio_pkg::HS_WAIT_RDY:  if (handshake_pin_b_i) tx_d = hsio_pkg::HS_WAIT_DROP;
			hsio_pkg::HS_WAIT_DROP: if (!handshake_pin_b_i) tx_d = hsio_pkg::HS_IDLE;
			default:                tx_d = hsio_pkg::HS_IDLE;
		endcase
		if (!send_mode) begin
			tx_d = hsio_pkg::HS_IDLE;
		end
	end

	// Sender state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q <= hsio_pkg::HS_IDLE;
		end else begin
			tx_q <= tx_d; // RULE_07
		end
	end

	// Receiver: capture on strobe low, raise ready, drop ready when strobe is released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_q     <= 1'b0;
			rxdata_q  <= hsio_pkg::DATA_RST;
			rx_full_q <= 1'b0;
		end else begin
			if (rx_take) begin
				rdy_q    <= 1'b1;     // RULE_07
				rxdata_q <= port_in;  // RULE_07
			end else if (rdy_q & (~recv_mode | handshake_pin_a_i)) begin
				rdy_q <= 1'b0;
			end
			// A new byte in the same cycle as the read keeps the flag set
			rx_full_q <= rx_take | (rx_full_q & ~rx_clear);
		end
	end

	// Handshake pads: the strobe line drives out when sending, ready line when receiving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_a_q <= hsio_pkg::PAD_RST;
			pad_b_q <= hsio_pkg::PAD_RST;
		end else begin
			pad_a_q.oe_n <= ~send_mode; // RULE_04 RULE_05
			pad_a_q.o    <= ~(tx_q == hsio_pkg::HS_WAIT_RDY); // RULE_07
			pad_b_q.oe_n <= ~recv_mode; // RULE_04 RULE_05
			pad_b_q.o    <= rx_take | (rdy_q & recv_mode & ~handshake_pin_a_i);
		end
	end

	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign port_out             = port_out_q;
	assign port_oe_n            = port_oe_n_q;
	assign handshake_pin_a_o    = pad_a_q.o;
	assign handshake_pin_a_oe_n = pad_a_q.oe_n;
	assign handshake_pin_b_o    = pad_b_q.o;
	assign handshake_pin_b_oe_n = pad_b_q.oe_n;

	// All-input direction releases every pad one cycle later
	property p_all_inputs_released;
		@(posedge pclk) disable iff (!presetn)
		(dir_q == 8'hFF) |=> (port_oe_n == 8'hFF);
	endproperty
	a_all_inputs_released: assert property (p_all_inputs_released) // RULE_01
		else $error("input lines still driven");

	// Open-drain never drives a high level
	property p_od_no_high;
		@(posedge pclk) disable iff (!presetn)
		ctrl_q.od [*2] |-> ((~port_oe_n & port_out) == 8'h00);
	endproperty
	a_od_no_high: assert property (p_od_no_high) // RULE_02
		else $error("open-drain line drove high");

	// A direction write always lands, whatever the handshake mode
	property p_dir_write_lands;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc & mapped & hit_dir) |=> (dir_q == $past(pwdata[7:0]));
	endproperty
	a_dir_write_lands: assert property (p_dir_write_lands) // RULE_03
		else $error("direction write lost");

	// Handshake off leaves both borrowed lines undriven
	property p_hs_off_released;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_q.hs_en) [*2] |-> (handshake_pin_a_oe_n & handshake_pin_b_oe_n);
	endproperty
	a_hs_off_released: assert property (p_hs_off_released) // RULE_04
		else $error("handshake line driven while off");

	// Exactly one handshake line is driven, chosen by the top line direction
	property p_role_by_top;
		@(posedge pclk) disable iff (!presetn)
		$stable(send_mode) && $stable(recv_mode) && hs_on |->
			(handshake_pin_a_oe_n == dir_q[7]) && (handshake_pin_b_oe_n == !dir_q[7]);
	endproperty
	a_role_by_top: assert property (p_role_by_top) // RULE_05
		else $error("handshake roles wrong");

	// Keeper holds every line while none is driven
	property p_keeper_holds;
		@(posedge pclk) disable iff (!presetn)
		(port_driven == 8'h00) |=> $stable(keep_q);
	endproperty
	a_keeper_holds: assert property (p_keeper_holds) // RULE_06
		else $error("undriven input changed");

	// Data stable on the pads at strobe fall and on the next cycle while the strobe stays low
	property p_data_before_strobe;
		@(posedge pclk) disable iff (!presetn)
		$fell(handshake_pin_a_o) && send_mode |->
			$stable(port_out) ##1 (handshake_pin_a_o || $stable(port_out));
	endproperty
	a_data_before_strobe: assert property (p_data_before_strobe) // RULE_07
		else $error("data moved under strobe");

	// A send write shows data first and drops the strobe one cycle after the pads
	property p_strobe_after_data;
		@(posedge pclk) disable iff (!presetn)
		(data_wr & send_mode) ##1 send_mode |=>
			handshake_pin_a_o ##1 !handshake_pin_a_o;
	endproperty
	a_strobe_after_data: assert property (p_strobe_after_data) // RULE_07
		else $error("strobe timing after data write wrong");

	// A captured byte raises ready and the full flag on the next cycle
	property p_ready_after_take;
		@(posedge pclk) disable iff (!presetn)
		rx_take |=> (handshake_pin_b_o & rx_full_q);
	endproperty
	a_ready_after_take: assert property (p_ready_after_take) // RULE_04
		else $error("ready or full flag missing after capture");

	// Ready falls once the strobe is seen released, so the next byte can start
	property p_ready_drops;
		@(posedge pclk) disable iff (!presetn)
		(recv_mode & rdy_q & handshake_pin_a_i) |=> !handshake_pin_b_o;
	endproperty
	a_ready_drops: assert property (p_ready_drops) // RULE_04
		else $error("ready held after strobe release");

	// A data write while busy leaves the data register untouched
	property p_busy_write_dropped;
		@(posedge pclk) disable iff (!presetn)
		(wr_acc & mapped & hit_data & tx_busy) |=> $stable(data_q);
	endproperty
	a_busy_write_dropped: assert property (p_busy_write_dropped) // RULE_07
		else $error("data changed during a transfer");
endmodule
`default_nettype wire

// ### include/hsio_pkg.sv
// Package: register map, field layout, reset values and types of the handshake I/O port
`default_nettype none
package hsio_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_DIR    = 8'h00;
	localparam logic [7:0] OFF_DATA   = 8'h04;
	localparam logic [7:0] OFF_CTRL   = 8'h08;
	localparam logic [7:0] OFF_PINS   = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RXDATA = 8'h14;
	// Field positions
	localparam int CTRL_OD_BIT     = 0;
	localparam int CTRL_HS_BIT     = 1;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_RXFULL_BIT = 1;
	localparam int TOP_LINE        = 7;
	// Reset values
	localparam logic [7:0] DIR_RST  = 8'hFF;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] KEEP_RST = 8'h00;
	// Port-wide control bits
	typedef struct packed {
		logic hs_en;
		logic od;
	} ctrl_t;
	localparam ctrl_t CTRL_RST = '{hs_en: 1'b0, od: 1'b0};
	// Pad drive of one two-way line
	typedef struct packed {
		logic o;
		logic oe_n;
	} pad_t;
	localparam pad_t PAD_RST = '{o: 1'b1, oe_n: 1'b1};
	// Sender handshake states, one-hot
	typedef enum logic [3:0] {
		HS_IDLE      = 4'b0001,
		HS_SETUP     = 4'b0010,
		HS_WAIT_RDY  = 4'b0100,
		HS_WAIT_DROP = 4'b1000
	} hs_state_t;
endpackage
`default_nettype wire

// ### verif/handshake_io_port_test.sv
// Self-checking bench for the handshake I/O port
`default_nettype none
module handshake_io_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] dir, data; logic od; logic [7:0] oe_n, out;} row_t;
	row_t rows [5] = '{'{8'h00, 8'hA5, 1'b0, 8'h00, 8'hA5}, '{8'h0F, 8'h3C, 1'b0, 8'h0F, 8'h3C},
		'{8'h00, 8'h5A, 1'b1, 8'h5A, 8'h5A}, '{8'hF0, 8'h0F, 1'b1, 8'hFF, 8'h0F},
		'{8'h81, 8'h81, 1'b0, 8'h81, 8'h81}};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, ext_val = 8'h00, ext_drv = 8'h00, port_out, port_oe_n, got, got_n;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, a_o, a_oe_n, b_o, b_oe_n, a_drv, b_drv, tx_go = 1'b0;
	logic [3:0]  lag = 4'h0;
	int          miscompares = 0, checks = 0, cyc = 0;
	// Wire levels resolved from the device's enables
	wire logic       a_lvl = a_oe_n ? a_drv : a_o;
	wire logic       b_lvl = b_oe_n ? b_drv : b_o;
	wire logic [7:0] port_in = (~port_oe_n & port_out) | (port_oe_n & ext_val);
	wire logic [7:0] port_driven = ext_drv & port_oe_n;
	handshake_io_port i_handshake_io_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .port_in, .port_driven, .port_out, .port_oe_n,
		.handshake_pin_a_i(a_lvl), .handshake_pin_a_o(a_o), .handshake_pin_a_oe_n(a_oe_n),
		.handshake_pin_b_i(b_lvl), .handshake_pin_b_o(b_o), .handshake_pin_b_oe_n(b_oe_n));
	hs_partner i_hs_partner (.pclk, .presetn, .a_lvl, .b_lvl, .dev_a_oe_n(a_oe_n),
		.port_lvl(port_in), .lag, .tx_go, .a_drv, .b_drv, .got, .got_n);
	always #12.5 pclk = ~pclk;
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer; an idle edge after it keeps drives one per time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk(n, 1);
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		rd = 32'h1;
		repeat (30) if (rd[0] !== 1'b0) apb(1'b0, hsio_pkg::OFF_STATUS, 32'h0);
	endtask
	// Hang guard, well past the length of all scenarios
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin miscompares++; wrap_up(); end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, hsio_pkg::OFF_CTRL, {31'h0, rows[i].od});
			apb(1'b1, hsio_pkg::OFF_DIR, {24'h0, rows[i].dir});
			apb(1'b1, hsio_pkg::OFF_DATA, {24'h0, rows[i].data});
			@(posedge pclk);
			chk(port_oe_n, rows[i].oe_n);
			chk(port_out, rows[i].out);
		end
		// Reset in mid-run releases every line
		presetn <= 1'b0;
		@(posedge pclk);
		chk({port_oe_n, port_out, a_oe_n, b_oe_n, pready}, {8'hFF, 8'h00, 3'b110});
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, hsio_pkg::OFF_DIR, 32'h0);
		chk(rd, 32'h0000_00FF);
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		// Keeper holds the last driven level once the outside lets go
		ext_drv <= 8'hFF; ext_val <= 8'hC3;
		repeat (2) @(posedge pclk);
		ext_drv <= 8'h00; ext_val <= 8'h3C;
		repeat (2) @(posedge pclk);
		apb(1'b0, hsio_pkg::OFF_PINS, 32'h0);
		chk(rd, 32'h0000_00C3);
		// Send: top line output, write during busy must be dropped
		apb(1'b1, hsio_pkg::OFF_CTRL, 32'h2);
		apb(1'b1, hsio_pkg::OFF_DIR, 32'h0);
		@(posedge pclk);
		chk({a_oe_n, b_oe_n}, 2'b01);
		apb(1'b1, hsio_pkg::OFF_DATA, 32'h96);
		apb(1'b1, hsio_pkg::OFF_DATA, 32'h11);
		wait_idle();
		chk({got_n, got}, 16'h0196);
		apb(1'b0, hsio_pkg::OFF_DATA, 32'h0);
		chk(rd, 32'h0000_0096);
		lag <= 4'h3;
		apb(1'b1, hsio_pkg::OFF_DATA, 32'h11);
		wait_idle();
		chk({got_n, got}, 16'h0211);
		// Receive: top line input, partner strobes a byte in
		apb(1'b1, hsio_pkg::OFF_DIR, 32'hFF);
		@(posedge pclk);
		chk({a_oe_n, b_oe_n}, 2'b10);
		ext_drv <= 8'hFF; ext_val <= 8'h5A;
		@(posedge pclk);
		tx_go <= 1'b1;
		@(posedge pclk);
		tx_go <= 1'b0;
		repeat (20) if (b_lvl !== 1'b1) @(posedge pclk);
		chk(b_lvl, 1'b1);
		apb(1'b0, hsio_pkg::OFF_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b0, hsio_pkg::OFF_RXDATA, 32'h0);
		chk(rd, 32'h0000_005A);
		apb(1'b0, hsio_pkg::OFF_STATUS, 32'h0);
		chk(rd[1], 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire

// ### verif/hs_partner.sv
// Far-side peripheral that trades bytes with the port over the two handshake lines
`default_nettype none
module hs_partner (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Wire levels and direction of the device
	input  wire logic       a_lvl,
	input  wire logic       b_lvl,
	input  wire logic       dev_a_oe_n,
	input  wire logic [7:0] port_lvl,
	// Bench control: reply delay and send request
	input  wire logic [3:0] lag,
	input  wire logic       tx_go,
	// Drives and captured bytes
	output logic            a_drv,
	output logic            b_drv,
	output logic [7:0]      got,
	output logic [7:0]      got_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] wait_q;
	// Receiver: take the byte on strobe after lag cycles, hold ready until strobe rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_drv <= 1'b0;
			wait_q <= 4'h0;
			got <= 8'h00;
			got_n <= 8'h00;
		end else if (!dev_a_oe_n && !a_lvl && !b_drv) begin
			wait_q <= (wait_q == lag) ? 4'h0 : wait_q + 4'h1;
			if (wait_q == lag) begin
				b_drv <= 1'b1;
				got <= port_lvl;
				got_n <= got_n + 8'h01;
			end
		end else if (a_lvl) begin
			b_drv <= 1'b0;
		end
	end
	// Sender: data is already on the lines when tx_go comes, strobe held until ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) a_drv <= 1'b1;
		else if (tx_go) a_drv <= 1'b0;
		else if (b_lvl) a_drv <= 1'b1;
	end
endmodule
`default_nettype wire
